/* rtl/cgv_regs.sv */
module cgv_regs
	import cgv_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// register port from the control interface
	input  wire logic [7:0]  page_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic        wr_en_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic        rd_en_in,
	output logic      [7:0]  rd_data_out,
	output logic             rd_valid_out,
	// raw codes
	output logic      [5:0]  gain_code_out,
	output logic      [7:0]  volume_code_out,
	// decoded settings for the signal path
	output logic      [5:0]  gain_db_out,
	output logic             gain_reserved_out,
	output logic             mute_out,
	output logic signed [8:0] vol_half_db_out
);

	logic [5:0] channel_four_gain_code_reg,   channel_four_gain_code_next;
	logic [7:0] channel_four_volume_code_reg, channel_four_volume_code_next;
	logic [7:0] rd_data_reg,  rd_data_next;
	logic       rd_valid_reg, rd_valid_next;
	logic       gain_hit;
	logic       vol_hit;

	cgv_cfg_if cfg ();

	// address decode shared by both paths
	assign gain_hit = cgv_hit(page_in, addr_in, CGV_GAIN_ADDR);
	assign vol_hit  = cgv_hit(page_in, addr_in, CGV_VOL_ADDR);

	// write path: only the addressed register changes
	always_comb begin
		channel_four_gain_code_next   = channel_four_gain_code_reg;
		channel_four_volume_code_next = channel_four_volume_code_reg;
		if (ce_in && wr_en_in) begin
			// reserved codes are stored as written, flagged downstream
			if (gain_hit) begin
				channel_four_gain_code_next =
					wr_data_in[7:CGV_GAIN_LSB];
			end
			if (vol_hit) begin
				channel_four_volume_code_next = wr_data_in;
			end
		end
	end

	// read path: data one cycle after the request, old value on collision
	always_comb begin
		rd_data_next  = rd_data_reg;
		rd_valid_next = rd_valid_reg;
		if (ce_in) begin
			rd_valid_next = rd_en_in;
			rd_data_next  = 8'h00; // unmapped reads as zero
			if (rd_en_in && gain_hit) begin
				rd_data_next = {channel_four_gain_code_reg,
					CGV_RSVD_ZERO};
			end else if (rd_en_in && vol_hit) begin
				rd_data_next = channel_four_volume_code_reg;
			end else if (!rd_en_in) begin
				rd_data_next = rd_data_reg; // hold last answer
			end
		end
	end

	// registers; reset gives 0 dB gain and 0 dB volume
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			channel_four_gain_code_reg   <= CGV_GAIN_RST;
			channel_four_volume_code_reg <= CGV_VOL_RST;
			rd_data_reg                  <= 8'h00;
			rd_valid_reg                 <= 1'b0;
		end else begin
			channel_four_gain_code_reg   <= channel_four_gain_code_next;
			channel_four_volume_code_reg <= channel_four_volume_code_next;
			rd_data_reg                  <= rd_data_next;
			rd_valid_reg                 <= rd_valid_next;
		end
	end

	// settings decode, one cycle behind the codes
	assign cfg.ce        = ce_in;
	assign cfg.gain_code = channel_four_gain_code_reg;
	assign cfg.vol_code  = channel_four_volume_code_reg;

	cgv_decode u_decode (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.cfg    (cfg.dec)
	);

	assign rd_data_out       = rd_data_reg;
	assign rd_valid_out      = rd_valid_reg;
	assign gain_code_out     = channel_four_gain_code_reg;
	assign volume_code_out   = channel_four_volume_code_reg;
	assign gain_db_out       = cfg.gain_db;
	assign gain_reserved_out = cfg.gain_rsvd;
	assign mute_out          = cfg.mute;
	assign vol_half_db_out   = cfg.vol_half_db;

	// port checks, one cycle after each taken strobe
	gain_write_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && gain_hit
		|=> gain_code_out == $past(wr_data_in[7:2]))
		else $error("gain write not stored");

	vol_write_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && vol_hit
		|=> volume_code_out == $past(wr_data_in))
		else $error("volume write not stored");

	gain_read_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && rd_en_in && gain_hit |=> rd_valid_out
		&& rd_data_out == {$past(gain_code_out), 2'b00})
		else $error("gain read wrong");

	vol_read_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && rd_en_in && vol_hit
		|=> rd_data_out == $past(volume_code_out))
		else $error("volume read wrong");

	// a read of a hole or of another page answers zero
	stray_read_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && rd_en_in && !gain_hit && !vol_hit
		|=> rd_valid_out && rd_data_out == 8'h00)
		else $error("unmapped read not zero");

	// the answer is a single-cycle pulse
	read_pulse_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && !rd_en_in
		|=> !rd_valid_out)
		else $error("read answer longer than one cycle");

	// data stays put until the next taken read
	read_hold_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		!ce_in || !rd_en_in
		|=> $stable(rd_data_out))
		else $error("read data moved without a read");

	// no disable on these two: they watch the reset itself
	reset_vals_a: assert property (@(posedge clk_in)
		rst_in |=> gain_code_out == 6'h00 && volume_code_out == 8'hC9
			&& !rd_valid_out)
		else $error("reset values wrong");

	reset_decode_a: assert property (@(posedge clk_in)
		rst_in |=> gain_db_out == 6'h00 && !gain_reserved_out
			&& !mute_out && vol_half_db_out == 9'sd0)
		else $error("decoded reset values wrong");

	// a write lands only in the register it names
	no_cross_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && gain_hit
		|=> $stable(volume_code_out))
		else $error("gain write disturbed volume");

	vol_no_cross_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && vol_hit
		|=> $stable(gain_code_out))
		else $error("volume write disturbed gain");

	stray_write_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && !gain_hit && !vol_hit
		|=> $stable(gain_code_out) && $stable(volume_code_out))
		else $error("unmapped write changed a register");

	// enable low must freeze the codes and the answer
	freeze_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		!ce_in |=> $stable(gain_code_out) && $stable(volume_code_out)
			&& $stable(rd_valid_out))
		else $error("state moved with enable low");

	// the decoded settings freeze with the codes
	decode_freeze_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		!ce_in |=> $stable(gain_db_out) && $stable(gain_reserved_out)
			&& $stable(mute_out) && $stable(vol_half_db_out))
		else $error("decoded settings moved with enable low");

	// decoded settings trail a write by two cycles
	mute_path_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && wr_en_in && vol_hit && wr_data_in == 8'h00
		##1 ce_in |=> mute_out)
		else $error("mute not reached after zero write");

	vol_unity_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		ce_in && volume_code_out == 8'hC9
		|=> vol_half_db_out == 9'sd0)
		else $error("code 201 is not 0 dB");

	// main scenarios; the bench reads back three cycles after a write
	gain_wr_c: cover property (@(posedge clk_in) disable iff (rst_in)
		ce_in && wr_en_in && gain_hit ##3 ce_in && rd_en_in && gain_hit);
	vol_wr_c: cover property (@(posedge clk_in) disable iff (rst_in)
		ce_in && wr_en_in && vol_hit && wr_data_in == 8'hFF);
	unmapped_c: cover property (@(posedge clk_in) disable iff (rst_in)
		ce_in && rd_en_in && !gain_hit && !vol_hit);

endmodule

/* rtl/cgv_pkg.sv */
package cgv_pkg;

	// register map, page zero only
	localparam logic [7:0] CGV_PAGE_ZERO = 8'h00;
	localparam logic [7:0] CGV_GAIN_ADDR = 8'h4C;
	localparam logic [7:0] CGV_VOL_ADDR  = 8'h4D;

	// field positions and widths
	localparam int CGV_GAIN_LSB = 2;
	localparam int CGV_GAIN_W   = 6;
	localparam int CGV_VOL_W    = 8;

	// values after reset
	localparam logic [5:0] CGV_GAIN_RST = 6'h00;
	localparam logic [7:0] CGV_VOL_RST  = 8'hC9;

	// code meanings
	localparam logic [5:0] CGV_GAIN_MAX  = 6'h2A;
	localparam logic [7:0] CGV_VOL_MUTE  = 8'h00;
	localparam logic [8:0] CGV_VOL_UNITY = 9'h0C9;
	localparam logic [1:0] CGV_RSVD_ZERO = 2'h0;

	// one decode shared by the write and the read path
	function automatic logic cgv_hit(input logic [7:0] page,
		input logic [7:0] addr, input logic [7:0] target);
		cgv_hit = (page == CGV_PAGE_ZERO) && (addr == target);
	endfunction

endpackage

/* rtl/cgv_cfg_if.sv */
interface cgv_cfg_if;
	import cgv_pkg::*;

	logic              ce;
	logic [5:0]        gain_code;
	logic [7:0]        vol_code;
	logic [5:0]        gain_db;
	logic              gain_rsvd;
	logic              mute;
	logic signed [8:0] vol_half_db;

	modport regs (output ce, gain_code, vol_code,
		input gain_db, gain_rsvd, mute, vol_half_db);
	modport dec (input ce, gain_code, vol_code,
		output gain_db, gain_rsvd, mute, vol_half_db);
endinterface

/* rtl/cgv_decode.sv */
module cgv_decode
	import cgv_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// codes in, settings out
	cgv_cfg_if.dec   cfg
);

	logic [5:0]        gain_db_reg,  gain_db_next;
	logic              rsvd_reg,     rsvd_next;
	logic              mute_reg,     mute_next;
	logic signed [8:0] vol_reg,      vol_next;

	// settings from codes; one register stage for timing
	always_comb begin
		gain_db_next = gain_db_reg;
		rsvd_next    = rsvd_reg;
		mute_next    = mute_reg;
		vol_next     = vol_reg;
		if (cfg.ce) begin
			// code value is the gain in whole dB
			gain_db_next = cfg.gain_code;
			rsvd_next    = cfg.gain_code > CGV_GAIN_MAX;
			mute_next    = cfg.vol_code == CGV_VOL_MUTE;
			// half-dB steps, code 201 is unity
			vol_next = $signed({1'b0, cfg.vol_code} - CGV_VOL_UNITY);
		end
	end

	// reset mirrors register reset: 0 dB gain, 0 dB volume
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			gain_db_reg <= CGV_GAIN_RST;
			rsvd_reg    <= 1'b0;
			mute_reg    <= 1'b0;
			vol_reg     <= 9'h000;
		end else begin
			gain_db_reg <= gain_db_next;
			rsvd_reg    <= rsvd_next;
			mute_reg    <= mute_next;
			vol_reg     <= vol_next;
		end
	end

	assign cfg.gain_db     = gain_db_reg;
	assign cfg.gain_rsvd   = rsvd_reg;
	assign cfg.mute        = mute_reg;
	assign cfg.vol_half_db = vol_reg;

	mute_follow_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		cfg.ce |=> cfg.mute == ($past(cfg.vol_code) == 8'h00))
		else $error("mute does not follow volume code zero");

	vol_scale_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		cfg.ce && cfg.vol_code == 8'hFF |=> cfg.vol_half_db == 9'sd54)
		else $error("code 255 is not +27 dB");

	gain_range_a: assert property (@(posedge clk_in)
		disable iff (rst_in)
		cfg.ce |=> cfg.gain_db == $past(cfg.gain_code)
			&& cfg.gain_rsvd == ($past(cfg.gain_code) > 6'h2A))
		else $error("gain setting wrong for code");

	mute_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
		cfg.mute);
	rsvd_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
		cfg.gain_rsvd);

endmodule

/* bench/cgv_regs_test.sv */
module cgv_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cgv_pkg::*;

	// design ports
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        ce_in = 1'b1;
	logic [7:0]  page_in = 8'h00;
	logic [7:0]  addr_in = 8'h00;
	logic        wr_en_in = 1'b0;
	logic [7:0]  wr_data_in = 8'h00;
	logic        rd_en_in = 1'b0;
	logic [7:0]  rd_data_out;
	logic        rd_valid_out;
	logic [5:0]  gain_code_out;
	logic [7:0]  volume_code_out;
	logic [5:0]  gain_db_out;
	logic        gain_reserved_out;
	logic        mute_out;
	logic signed [8:0] vol_half_db_out;
	// bookkeeping
	int          mismatches = 0;
	int          n_tests = 0;
	logic [7:0]  q;
	// boundary codes of both fields, reserved gains included
	logic [5:0]  gains [6] = '{6'h00, 6'h01, 6'h02, 6'h2A, 6'h2B, 6'h3F};
	logic [7:0]  vols [7] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFE,
		8'hFF};

	cgv_regs cgv_regs_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.page_in(page_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
		.wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.gain_code_out(gain_code_out), .volume_code_out(volume_code_out),
		.gain_db_out(gain_db_out), .gain_reserved_out(gain_reserved_out),
		.mute_out(mute_out), .vol_half_db_out(vol_half_db_out));

	// 40 ns period
	always #20 clk_in = ~clk_in;

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one strobe cycle; returns just after the taking edge
	task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
		input logic [7:0] d);
		@(posedge clk_in);
		page_in <= pg;
		addr_in <= ad;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
		#1;
	endtask

	// answer is due exactly one cycle after the strobe
	task automatic rd(input logic [7:0] pg, input logic [7:0] ad,
		output logic [7:0] d);
		@(posedge clk_in);
		page_in <= pg;
		addr_in <= ad;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk({8'h00, rd_valid_out}, 9'h001);
		d = rd_data_out;
	endtask

	// reset mid-run too, so state from earlier tests must be wiped
	task automatic do_reset();
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		chk({3'h0, gain_code_out}, 9'h000);
		chk({1'b0, volume_code_out}, 9'h0C9);
		chk({8'h00, mute_out}, 9'h000);
		rd(8'h00, CGV_GAIN_ADDR, q);
		chk({1'b0, q}, 9'h000);
		rd(8'h00, CGV_VOL_ADDR, q);
		chk({1'b0, q}, 9'h0C9);
	endtask

	task automatic complete_run();
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence
	initial begin
		do_reset();
		// reserved low bits written as ones must read back zero; codes
		// 2B and 3F break the host's side of the gain range on purpose
		foreach (gains[i]) begin
			wr(8'h00, CGV_GAIN_ADDR, {gains[i], 2'b11});
			chk({3'h0, gain_code_out}, {3'h0, gains[i]});
			@(posedge clk_in);
			#1;
			chk({3'h0, gain_db_out}, {3'h0, gains[i]});
			chk({8'h00, gain_reserved_out}, {8'h00, gains[i] > 6'h2A});
			rd(8'h00, CGV_GAIN_ADDR, q);
			chk({1'b0, q}, {1'b0, gains[i], 2'b00});
		end
		foreach (vols[i]) begin
			wr(8'h00, CGV_VOL_ADDR, vols[i]);
			chk({1'b0, volume_code_out}, {1'b0, vols[i]});
			@(posedge clk_in);
			#1;
			chk({8'h00, mute_out}, {8'h00, vols[i] == 8'h00});
			chk(vol_half_db_out, {1'b0, vols[i]} - 9'h0C9);
			rd(8'h00, CGV_VOL_ADDR, q);
			chk({1'b0, q}, {1'b0, vols[i]});
		end
		// wrong page and unmapped address leave both registers alone
		wr(8'h01, CGV_GAIN_ADDR, 8'h54);
		wr(8'h00, 8'h4E, 8'h55);
		rd(8'h00, CGV_GAIN_ADDR, q);
		chk({1'b0, q}, 9'h0FC);
		rd(8'h00, CGV_VOL_ADDR, q);
		chk({1'b0, q}, 9'h0FF);
		// answer lasts one cycle, data stays until the next read
		@(posedge clk_in);
		#1;
		chk({8'h00, rd_valid_out}, 9'h000);
		chk({1'b0, rd_data_out}, 9'h0FF);
		rd(8'h00, 8'h4E, q);
		chk({1'b0, q}, 9'h000);
		rd(8'h01, CGV_VOL_ADDR, q);
		chk({1'b0, q}, 9'h000);
		// writing one register must not disturb the other
		wr(8'h00, CGV_VOL_ADDR, 8'h00);
		chk({3'h0, gain_code_out}, 9'h03F);
		// a write with the enable low is not taken, decode freezes too
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(8'h00, CGV_VOL_ADDR, 8'h10);
		@(posedge clk_in);
		ce_in <= 1'b1;
		#1;
		chk({1'b0, volume_code_out}, 9'h000);
		chk({8'h00, mute_out}, 9'h001);
		do_reset();
		complete_run();
	end

	// the tests need about a hundred cycles; this allows far more
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule
